// [hdl/lpmcs_clk_mon.sv]
`timescale 1ns/100ps
module lpmcs_clk_mon import lpmcs_pkg::*; (
  input logic core_clk_i,
  input logic resetn_i,
  input logic clk_en_i,
  input logic mon_en_i,
  input logic ext_tick_i,
  output logic fail_o
);

  logic tick_prev_reg;
  logic [CNT_W-1:0] gap_reg;
  logic [CNT_W-1:0] gap_next;
  logic fail_reg;
  logic edge_seen;
  logic expire;

  // any edge of the divided external tick proves the source alive
  assign edge_seen = ext_tick_i ^ tick_prev_reg;
  assign expire = mon_en_i & !edge_seen & (gap_reg == MON_LIMIT - 8'h01);
  assign gap_next = (!mon_en_i || edge_seen) ? '0 :
                    (gap_reg < MON_LIMIT) ? gap_reg + 8'h01 : gap_reg;
  assign fail_o = fail_reg;

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      tick_prev_reg <= 1'b0;
      gap_reg <= '0;
      fail_reg <= 1'b0;
    end else if (clk_en_i) begin
      tick_prev_reg <= ext_tick_i;
      gap_reg <= gap_next;
      fail_reg <= expire;
    end
  end

endmodule // lpmcs_clk_mon

// [hdl/lpmcs_prescaler.sv]
`timescale 1ns/100ps
module lpmcs_prescaler import lpmcs_pkg::*; (
  input logic core_clk_i,
  input logic resetn_i,
  input logic clk_en_i,
  input logic run_i,
  input logic [DIV_W-1:0] div_sel_i,
  output logic tick_o
);

  logic [PRESC_CNT_W-1:0] cnt_reg;
  logic [PRESC_CNT_W-1:0] cnt_next;
  logic [PRESC_CNT_W-1:0] last_cnt;
  logic wrap;

  // divide by 2^div_sel; a shrinking ratio wraps at once
  assign last_cnt = (PRESC_CNT_W'(1) << div_sel_i) - PRESC_CNT_W'(1);
  assign wrap = cnt_reg >= last_cnt;
  assign cnt_next = (!run_i || wrap) ? '0 : cnt_reg + PRESC_CNT_W'(1);
  assign tick_o = clk_en_i & run_i & wrap;

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cnt_reg <= '0;
    end else if (clk_en_i) begin
      cnt_reg <= cnt_next;
    end
  end

endmodule // lpmcs_prescaler

// [hdl/lpmcs_top.sv]
// What this block does
// - sleep halts only the core clock; peripherals stay clocked.
// - any peripheral interrupt wakes the core from sleep; stop wakeup events do not.
// - stop gates core-domain clocks, pll and both oscillators; contents kept.
// - regulator in stop is normal or low-power as configured at entry.
// - any event line, detector, calendar, port, comparator or cec leaves stop.
// - cec, serial and two-wire ports may request the rc clock in stop.
// - with low-power regulator, regulator returns to normal before clock given.
// - standby switches regulator, pll and both oscillators off.
// - standby loses core contents; calendar and standby circuitry are kept.
// - reset pin low, guard reset, wakeup rise or calendar event exit standby.
// - calendar, guard timer and their clocks keep running in stop/standby.
// - after reset the rc oscillator clocks the core until software changes.
// - external clock of 4 to 32 MHz selectable, supervised while in use.
// - external clock failure falls back to rc oscillator automatically.
// - failure interrupt is raised only when its enable is set.
// - bus clocks come from prescalers and never exceed 48 MHz.
// - five 32-bit backup registers survive reset and standby wakeup.
`timescale 1ns/100ps
module lpmcs_top import lpmcs_pkg::*; (
  input logic core_clk_i,
  input logic resetn_i,
  input logic clk_en_i,
  // core side
  input logic lp_entry_i,
  input logic deep_sleep_i,
  input logic standby_sel_i,
  input logic lp_regulator_sel_i,
  input logic periph_irq_i,
  // stop wakeup sources
  input logic [NUM_EXT_LINES-1:0] external_event_lines_i,
  input logic supply_level_detector_i,
  input logic calendar_evt_i,
  input logic first_two_wire_port_wake_i,
  input logic first_serial_port_wake_i,
  input logic [NUM_CMP-1:0] comparator_outputs_i,
  input logic cec_wake_i,
  // rc clock requests in stop
  input logic [NUM_RC_REQ-1:0] rc_req_i,
  input logic [NUM_RC_REQ-1:0] rc_req_en_i,
  output logic [NUM_RC_REQ-1:0] rc_grant_o,
  // standby wakeup sources
  input logic external_reset_pin_n_i,
  input logic independent_guard_timer_rst_i,
  input logic [NUM_WAKEUP_PINS_PINS-1:0] wakeup_pins_i,
  // clock configuration
  input logic ext_osc_on_i,
  input logic [5:0] ext_freq_mhz_i,
  input logic pll_on_i,
  input logic pll_src_ext_i,
  input logic [6:0] pll_freq_mhz_i,
  input logic clk_sel_wr_i,
  input lpmcs_src_t clk_sel_i,
  input logic div_wr_i,
  input logic [DIV_W-1:0] hdiv_sel_i,
  input logic [DIV_W-1:0] pdiv_sel_i,
  input logic ext_tick_i,
  input logic clk_fail_irq_en_i,
  input logic clk_fail_clr_i,
  input logic standby_flag_clr_i,
  // backup registers
  input logic bkp_wr_i,
  input logic [BKP_IDX_W-1:0] bkp_idx_i,
  input logic [BKP_W-1:0] bkp_wdata_i,
  output logic [BKP_W-1:0] bkp_rdata_o,
  // clock, oscillator and power controls
  output lpmcs_src_t sysclk_sel_o,
  output logic [DIV_W-1:0] hdiv_o,
  output logic [DIV_W-1:0] pdiv_o,
  output logic core_clk_en_o,
  output logic hclk_en_o,
  output logic pclk_en_o,
  output logic core_domain_clk_on_o,
  output logic pll_en_o,
  output logic internal_rc_osc_en_o,
  output logic external_crystal_osc_en_o,
  output logic regulator_on_o,
  output logic regulator_lp_o,
  output logic core_domain_rst_n_o,
  output logic calendar_clk_en_o,
  output logic guard_timer_clk_en_o,
  output logic clk_fail_flag_o,
  output logic clk_fail_irq_o,
  output logic standby_flag_o
);

  lpmcs_state_t state_reg;
  lpmcs_state_t state_next;
  lpmcs_src_t sel_reg;
  lpmcs_src_t sel_next;
  logic lp_reg_reg;
  logic [CNT_W-1:0] settle_reg;
  logic [CNT_W-1:0] settle_next;
  logic [DIV_W-1:0] hdiv_reg;
  logic [DIV_W-1:0] pdiv_reg;
  logic fail_flag_reg;
  logic standby_flag_reg;
  logic [NUM_WAKEUP_PINS_PINS-1:0] wakeup_pins_prev_reg;
  logic [BKP_W-1:0] bkp_mem [NUM_BKP_REGS];
  logic [BKP_W-1:0] bkp_rdata_reg;

  function automatic logic [7:0] src_mhz(input lpmcs_src_t s,
                                         input logic [7:0] ext_mhz,
                                         input logic [7:0] pll_mhz);
    case (s)
      LPMCS_SRC_EXT: src_mhz = ext_mhz;
      LPMCS_SRC_PLL: src_mhz = pll_mhz;
      default: src_mhz = RC_OSC_MHZ;
    endcase
  endfunction

  function automatic logic bus_ok(input logic [7:0] mhz,
                                  input logic [3:0] sh);
    bus_ok = {16'h0000, mhz} <= (BUS_MAX_MHZ << sh);
  endfunction

  // state decode
  logic in_run;
  logic in_sleep;
  logic in_stop;
  logic in_regup;
  logic in_stop_rc;
  logic in_standby;
  logic domain_on;
  assign in_run = state_reg == ST_RUN;
  assign in_sleep = state_reg == ST_SLEEP;
  assign in_stop = state_reg == ST_STOP;
  assign in_regup = state_reg == ST_STOP_REGUP;
  assign in_stop_rc = state_reg == ST_STOP_RC;
  assign in_standby = state_reg == ST_STANDBY;
  assign domain_on = in_run | in_sleep;

  // wakeup sources
  logic stop_wake;
  logic [NUM_WAKEUP_PINS_PINS-1:0] wakeup_pins_rise;
  logic standby_wake;
  logic [NUM_RC_REQ-1:0] rc_req_live;
  logic any_rc_req;
  logic stop_exit;
  assign stop_wake = (|external_event_lines_i) | supply_level_detector_i |
                     calendar_evt_i | first_two_wire_port_wake_i |
                     first_serial_port_wake_i | (|comparator_outputs_i) |
                     cec_wake_i;
  assign wakeup_pins_rise = wakeup_pins_i & ~wakeup_pins_prev_reg;
  assign standby_wake = !external_reset_pin_n_i |
                        independent_guard_timer_rst_i |
                        (|wakeup_pins_rise) | calendar_evt_i;
  assign rc_req_live = rc_req_i & rc_req_en_i;
  assign any_rc_req = |rc_req_live;
  assign stop_exit = (in_stop | in_regup | in_stop_rc) & stop_wake;

  // clock selection and prescaler legality
  logic [7:0] ext_mhz;
  logic [7:0] pll_mhz;
  logic [7:0] cur_mhz;
  logic [7:0] new_mhz;
  logic ext_ok;
  logic target_ok;
  logic sel_legal;
  logic div_legal;
  logic ext_in_use;
  logic mon_en;
  logic mon_fail;
  assign ext_mhz = {2'h0, ext_freq_mhz_i};
  assign pll_mhz = {1'h0, pll_freq_mhz_i};
  assign cur_mhz = src_mhz(sel_reg, ext_mhz, pll_mhz);
  assign new_mhz = src_mhz(clk_sel_i, ext_mhz, pll_mhz);
  assign ext_ok = ext_osc_on_i & (ext_freq_mhz_i >= EXT_MIN_MHZ) &
                  (ext_freq_mhz_i <= EXT_MAX_MHZ);
  assign target_ok = (clk_sel_i == LPMCS_SRC_RC) |
                     ((clk_sel_i == LPMCS_SRC_EXT) & ext_ok) |
                     ((clk_sel_i == LPMCS_SRC_PLL) & pll_on_i &
                      (!pll_src_ext_i | ext_ok));
  assign sel_legal = clk_sel_wr_i & in_run & target_ok &
                     bus_ok(new_mhz, {1'b0, hdiv_reg}) &
                     bus_ok(new_mhz, {1'b0, hdiv_reg} + {1'b0, pdiv_reg});
  // a clock switch in the same cycle wins over a divider write
  assign div_legal = div_wr_i & in_run & !clk_sel_wr_i &
                     bus_ok(cur_mhz, {1'b0, hdiv_sel_i}) &
                     bus_ok(cur_mhz, {1'b0, hdiv_sel_i} +
                            {1'b0, pdiv_sel_i});
  assign ext_in_use = (sel_reg == LPMCS_SRC_EXT) |
                      ((sel_reg == LPMCS_SRC_PLL) & pll_src_ext_i);
  assign mon_en = ext_in_use & domain_on;

  lpmcs_clk_mon u_clk_mon (
    .core_clk_i (core_clk_i),
    .resetn_i (resetn_i),
    .clk_en_i (clk_en_i),
    .mon_en_i (mon_en),
    .ext_tick_i (ext_tick_i),
    .fail_o (mon_fail)
  );

  // system clock source: rc after reset, failure, stop exit or standby
  assign sel_next = (in_standby || mon_fail || stop_exit) ? LPMCS_SRC_RC :
                    sel_legal ? clk_sel_i : sel_reg;

  // bus clock prescalers
  logic hclk_tick;
  logic pclk_tick;
  lpmcs_prescaler u_hclk_div (
    .core_clk_i (core_clk_i),
    .resetn_i (resetn_i),
    .clk_en_i (clk_en_i),
    .run_i (domain_on),
    .div_sel_i (hdiv_reg),
    .tick_o (hclk_tick)
  );
  lpmcs_prescaler u_pclk_div (
    .core_clk_i (core_clk_i),
    .resetn_i (resetn_i),
    .clk_en_i (hclk_tick),
    .run_i (domain_on),
    .div_sel_i (pdiv_reg),
    .tick_o (pclk_tick)
  );

  // mode sequencing
  always_comb begin
    state_next = state_reg;
    settle_next = settle_reg;
    case (state_reg)
      ST_RUN: begin
        if (lp_entry_i) begin
          if (!deep_sleep_i) begin
            state_next = ST_SLEEP;
          end else if (standby_sel_i) begin
            state_next = ST_STANDBY;
          end else begin
            state_next = ST_STOP;
          end
        end
      end
      ST_SLEEP: begin
        if (periph_irq_i) begin
          state_next = ST_RUN;
        end
      end
      ST_STOP: begin
        if (stop_wake) begin
          state_next = ST_RUN;
        end else if (any_rc_req && lp_reg_reg) begin
          state_next = ST_STOP_REGUP;
          settle_next = SETTLE_LOAD;
        end else if (any_rc_req) begin
          state_next = ST_STOP_RC;
        end
      end
      ST_STOP_REGUP: begin
        if (stop_wake) begin
          state_next = ST_RUN;
        end else if (!any_rc_req) begin
          state_next = ST_STOP;
        end else if (settle_reg == '0) begin
          state_next = ST_STOP_RC;
        end else begin
          settle_next = settle_reg - 8'h01;
        end
      end
      ST_STOP_RC: begin
        if (stop_wake) begin
          state_next = ST_RUN;
        end else if (!any_rc_req) begin
          state_next = ST_STOP;
        end
      end
      ST_STANDBY: begin
        if (standby_wake) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state_reg <= ST_RUN;
      settle_reg <= '0;
      lp_reg_reg <= 1'b0;
      wakeup_pins_prev_reg <= '0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
      settle_reg <= settle_next;
      wakeup_pins_prev_reg <= wakeup_pins_i;
      if (in_run && lp_entry_i && deep_sleep_i) begin
        lp_reg_reg <= lp_regulator_sel_i;
      end
    end
  end

  // core-domain configuration is lost across standby
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      sel_reg <= LPMCS_SRC_RC;
      hdiv_reg <= HDIV_RESET;
      pdiv_reg <= PDIV_RESET;
    end else if (clk_en_i) begin
      sel_reg <= sel_next;
      if (in_standby) begin
        hdiv_reg <= HDIV_RESET;
        pdiv_reg <= PDIV_RESET;
      end else if (div_legal) begin
        hdiv_reg <= hdiv_sel_i;
        pdiv_reg <= pdiv_sel_i;
      end
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      fail_flag_reg <= 1'b0;
      standby_flag_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (in_standby) begin
        fail_flag_reg <= 1'b0;
      end else begin
        fail_flag_reg <= mon_fail | (fail_flag_reg & !clk_fail_clr_i);
      end
      standby_flag_reg <= in_standby |
                          (standby_flag_reg & !standby_flag_clr_i);
    end
  end

  // backup registers: no reset, kept through standby
  logic bkp_hit;
  assign bkp_hit = bkp_wr_i & !in_standby &
                   (bkp_idx_i < BKP_IDX_W'(NUM_BKP_REGS));
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i && bkp_hit) begin
      bkp_mem[bkp_idx_i] <= bkp_wdata_i;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      bkp_rdata_reg <= '0;
    end else if (clk_en_i) begin
      bkp_rdata_reg <= (bkp_idx_i < BKP_IDX_W'(NUM_BKP_REGS)) ?
                       bkp_mem[bkp_idx_i] : '0;
    end
  end

  // outputs
  assign sysclk_sel_o = sel_reg;
  assign hdiv_o = hdiv_reg;
  assign pdiv_o = pdiv_reg;
  assign core_clk_en_o = hclk_tick & in_run;
  assign hclk_en_o = hclk_tick;
  assign pclk_en_o = pclk_tick;
  assign core_domain_clk_on_o = domain_on;
  assign pll_en_o = pll_on_i & domain_on;
  assign internal_rc_osc_en_o = domain_on | in_stop_rc;
  assign external_crystal_osc_en_o = ext_osc_on_i & domain_on;
  assign regulator_on_o = !in_standby;
  assign regulator_lp_o = in_stop & lp_reg_reg;
  assign core_domain_rst_n_o = !in_standby;
  assign calendar_clk_en_o = 1'b1;
  assign guard_timer_clk_en_o = 1'b1;
  assign rc_grant_o = in_stop_rc ? rc_req_live : '0;
  assign clk_fail_flag_o = fail_flag_reg;
  assign clk_fail_irq_o = fail_flag_reg & clk_fail_irq_en_i;
  assign standby_flag_o = standby_flag_reg;
  assign bkp_rdata_o = bkp_rdata_reg;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  AST_SLEEP_HALT: assert property (
    in_sleep |-> !core_clk_en_o && core_domain_clk_on_o)
    else $error("core clocked in sleep");
  AST_SLEEP_WAKE: assert property (
    clk_en_i && in_sleep && periph_irq_i |=> in_run)
    else $error("sleep did not wake on interrupt");
  AST_STOP_GATED: assert property (
    in_stop |-> !pll_en_o && !internal_rc_osc_en_o &&
    !external_crystal_osc_en_o && !hclk_en_o && regulator_on_o)
    else $error("clock or oscillator alive in stop");
  AST_STOP_REG: assert property (
    clk_en_i && in_run && lp_entry_i && deep_sleep_i && !standby_sel_i
    |=> in_stop && (regulator_lp_o == $past(lp_regulator_sel_i)))
    else $error("stop regulator mode wrong");
  AST_STOP_WAKE: assert property (
    clk_en_i && in_stop && stop_wake |=> in_run &&
    sysclk_sel_o == LPMCS_SRC_RC)
    else $error("stop wake failed");
  AST_RC_GRANT: assert property (
    clk_en_i && in_stop && !stop_wake && any_rc_req && !lp_reg_reg
    |=> in_stop_rc && internal_rc_osc_en_o && rc_grant_o == rc_req_live)
    else $error("rc request not granted");
  AST_REG_FIRST: assert property (
    $rose(|rc_grant_o) && lp_reg_reg |->
    $past(in_regup) && $past(settle_reg) == '0 && !regulator_lp_o)
    else $error("rc clock before regulator normal");
  AST_STANDBY_OFF: assert property (
    in_standby |-> !regulator_on_o && !pll_en_o && !internal_rc_osc_en_o &&
    !external_crystal_osc_en_o && !core_domain_rst_n_o)
    else $error("standby power still on");
  AST_STANDBY_LOSS: assert property (
    clk_en_i && in_standby |=> hdiv_o == HDIV_RESET && standby_flag_o)
    else $error("standby kept core state");
  AST_STANDBY_EXIT: assert property (
    clk_en_i && in_standby && !external_reset_pin_n_i |=> in_run)
    else $error("standby exit missed");
  AST_ALWAYS_ON: assert property (
    (in_stop || in_standby) |-> calendar_clk_en_o && guard_timer_clk_en_o)
    else $error("calendar clock stopped");
  AST_RESET_RC: assert property (
    $rose(resetn_i) |-> sysclk_sel_o == LPMCS_SRC_RC)
    else $error("reset source not rc");
  AST_MON_ON: assert property (
    sysclk_sel_o == LPMCS_SRC_EXT && in_run |-> mon_en)
    else $error("external clock unsupervised");
  AST_FALLBACK: assert property (
    clk_en_i && mon_fail |=> sysclk_sel_o == LPMCS_SRC_RC &&
    clk_fail_flag_o)
    else $error("no fallback on clock failure");
  AST_IRQ_GATE: assert property (
    clk_fail_irq_o |-> clk_fail_irq_en_i && clk_fail_flag_o)
    else $error("failure irq without enable");
  AST_BUS_MAX: assert property (
    bus_ok(cur_mhz, {1'b0, hdiv_reg}) &&
    bus_ok(cur_mhz, {1'b0, hdiv_reg} + {1'b0, pdiv_reg}))
    else $error("bus clock above limit");
  AST_BKP_KEEP: assert property (
    clk_en_i && bkp_hit |=> bkp_mem[$past(bkp_idx_i)] == $past(bkp_wdata_i))
    else $error("backup write lost");

endmodule // lpmcs_top

// [pkg/lpmcs_pkg.sv]
package lpmcs_pkg;

  // core clock
  localparam int CORE_CLK_PERIOD_NS = 50;

  // regulator return from low-power to normal before a clock is handed out
  localparam int REG_SETTLE_NS = 2000;
  localparam int REG_SETTLE_CYC_RAW =
    (REG_SETTLE_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int REG_SETTLE_CYC =
    (REG_SETTLE_CYC_RAW < 1) ? 1 : REG_SETTLE_CYC_RAW;

  // external clock declared dead after this long without a tick edge
  localparam int CLK_MON_TIMEOUT_NS = 1000;
  localparam int CLK_MON_CYC_RAW = CLK_MON_TIMEOUT_NS / CORE_CLK_PERIOD_NS;
  localparam int CLK_MON_CYC = (CLK_MON_CYC_RAW < 1) ? 1 : CLK_MON_CYC_RAW;

  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(REG_SETTLE_CYC - 1);
  localparam logic [CNT_W-1:0] MON_LIMIT = CNT_W'(CLK_MON_CYC);

  // clock figures in MHz
  localparam logic [7:0] RC_OSC_MHZ = 8'h08;
  localparam logic [5:0] EXT_MIN_MHZ = 6'h04;
  localparam logic [5:0] EXT_MAX_MHZ = 6'h20;
  localparam logic [23:0] BUS_MAX_MHZ = 24'h000030;

  // sizes
  localparam int NUM_EXT_LINES = 16;
  localparam int NUM_CMP = 2;
  localparam int NUM_WAKEUP_PINS_PINS = 2;
  localparam int NUM_RC_REQ = 3;
  localparam int NUM_BKP_REGS = 5;
  localparam int BKP_W = 32;
  localparam int BKP_IDX_W = 3;
  localparam int DIV_W = 3;
  localparam int PRESC_CNT_W = 7;

  // values after reset
  localparam logic [DIV_W-1:0] HDIV_RESET = 3'h0;
  localparam logic [DIV_W-1:0] PDIV_RESET = 3'h0;

  // rc request slots
  localparam int RCREQ_CEC = 0;
  localparam int RCREQ_SERIAL = 1;
  localparam int RCREQ_TWO_WIRE = 2;

  typedef enum logic [1:0] {
    LPMCS_SRC_RC,
    LPMCS_SRC_EXT,
    LPMCS_SRC_PLL
  } lpmcs_src_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_STOP,
    ST_STOP_REGUP,
    ST_STOP_RC,
    ST_STANDBY
  } lpmcs_state_t;

endpackage

// [tb/lpmcs_far_end.sv]
`timescale 1ns/100ps
module lpmcs_far_end import lpmcs_pkg::*; (
  input logic core_clk_i,
  input logic resetn_i,
  input logic tick_on_i,
  input logic osc_en_i,
  input logic [NUM_RC_REQ-1:0] want_i,
  output logic tick_o,
  output logic [NUM_RC_REQ-1:0] req_o
);
  logic tick_reg;
  logic [NUM_RC_REQ-1:0] req_reg;

  // crystal divides down to a toggling level only while it is powered
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      tick_reg <= 1'h0;
      req_reg <= '0;
    end else begin
      if (tick_on_i && osc_en_i) begin
        tick_reg <= ~tick_reg;
      end
      req_reg <= want_i;
    end
  end

  assign tick_o = tick_reg;
  assign req_o = req_reg;
endmodule // lpmcs_far_end

// [tb/tb_lpmcs_top.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %0t mismatch got %0h want %0h", $time, (a), (e)); end end
module tb_lpmcs_top import lpmcs_pkg::*;;
  logic core_clk_i, resetn_i, clk_en_i, lp_entry_i, deep_sleep_i;
  logic standby_sel_i, lp_regulator_sel_i, periph_irq_i;
  logic [NUM_EXT_LINES-1:0] external_event_lines_i;
  logic supply_level_detector_i, calendar_evt_i, first_two_wire_port_wake_i;
  logic first_serial_port_wake_i, cec_wake_i, cal_sb, tick_on, ext_tick_i;
  logic [NUM_CMP-1:0] comparator_outputs_i;
  logic [NUM_RC_REQ-1:0] rc_req_i, rc_req_en_i, rc_grant_o, want_rc;
  logic external_reset_pin_n_i, independent_guard_timer_rst_i;
  logic [NUM_WAKEUP_PINS_PINS-1:0] wakeup_pins_i;
  logic ext_osc_on_i, pll_on_i, pll_src_ext_i, clk_sel_wr_i, div_wr_i;
  logic [5:0] ext_freq_mhz_i;
  logic [6:0] pll_freq_mhz_i;
  lpmcs_src_t clk_sel_i, sysclk_sel_o;
  logic [DIV_W-1:0] hdiv_sel_i, pdiv_sel_i, hdiv_o, pdiv_o;
  logic clk_fail_irq_en_i, clk_fail_clr_i, standby_flag_clr_i, bkp_wr_i;
  logic [BKP_IDX_W-1:0] bkp_idx_i;
  logic [BKP_W-1:0] bkp_wdata_i, bkp_rdata_o;
  logic core_clk_en_o, hclk_en_o, pclk_en_o, core_domain_clk_on_o, pll_en_o;
  logic internal_rc_osc_en_o, external_crystal_osc_en_o, regulator_on_o;
  logic regulator_lp_o, core_domain_rst_n_o, calendar_clk_en_o;
  logic guard_timer_clk_en_o, clk_fail_flag_o, clk_fail_irq_o, standby_flag_o;
  logic [22:0] stop_src;
  int errors, n_compared, k, cnt;

  assign {external_event_lines_i, supply_level_detector_i} = stop_src[22:6];
  assign calendar_evt_i = stop_src[5] | cal_sb;
  assign {first_two_wire_port_wake_i, first_serial_port_wake_i} =
    stop_src[4:3];
  assign {comparator_outputs_i, cec_wake_i} = stop_src[2:0];

  lpmcs_top dut (.core_clk_i, .resetn_i, .clk_en_i, .lp_entry_i,
    .deep_sleep_i, .standby_sel_i, .lp_regulator_sel_i, .periph_irq_i,
    .external_event_lines_i, .supply_level_detector_i, .calendar_evt_i,
    .first_two_wire_port_wake_i, .first_serial_port_wake_i,
    .comparator_outputs_i, .cec_wake_i, .rc_req_i, .rc_req_en_i, .rc_grant_o,
    .external_reset_pin_n_i, .independent_guard_timer_rst_i, .wakeup_pins_i,
    .ext_osc_on_i, .ext_freq_mhz_i, .pll_on_i, .pll_src_ext_i,
    .pll_freq_mhz_i, .clk_sel_wr_i, .clk_sel_i, .div_wr_i, .hdiv_sel_i,
    .pdiv_sel_i, .ext_tick_i, .clk_fail_irq_en_i, .clk_fail_clr_i,
    .standby_flag_clr_i, .bkp_wr_i, .bkp_idx_i, .bkp_wdata_i, .bkp_rdata_o,
    .sysclk_sel_o, .hdiv_o, .pdiv_o, .core_clk_en_o, .hclk_en_o, .pclk_en_o,
    .core_domain_clk_on_o, .pll_en_o, .internal_rc_osc_en_o,
    .external_crystal_osc_en_o, .regulator_on_o, .regulator_lp_o,
    .core_domain_rst_n_o, .calendar_clk_en_o, .guard_timer_clk_en_o,
    .clk_fail_flag_o, .clk_fail_irq_o, .standby_flag_o);

  lpmcs_far_end far (.core_clk_i, .resetn_i, .tick_on_i(tick_on),
    .osc_en_i(external_crystal_osc_en_o), .want_i(want_rc),
    .tick_o(ext_tick_i), .req_o(rc_req_i));

  initial begin
    core_clk_i = 1'h0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  task automatic step(input int n = 1);
    repeat (n) begin
      @(posedge core_clk_i);
      #1;
    end
  endtask

  task automatic complete_run();
    if (errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic bound(input int n);
    if (k >= n) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic enter(input logic d, input logic s, input logic l);
    deep_sleep_i = d;
    standby_sel_i = s;
    lp_regulator_sel_i = l;
    lp_entry_i = 1'h1;
    step();
    lp_entry_i = 1'h0;
  endtask

  task automatic sel(input lpmcs_src_t s);
    clk_sel_i = s;
    clk_sel_wr_i = 1'h1;
    step();
    clk_sel_wr_i = 1'h0;
    step();
  endtask

  initial begin
    {lp_entry_i, deep_sleep_i, standby_sel_i, lp_regulator_sel_i} = '0;
    {periph_irq_i, cal_sb, tick_on, independent_guard_timer_rst_i} = '0;
    {ext_osc_on_i, pll_on_i, pll_src_ext_i, clk_sel_wr_i, div_wr_i} = '0;
    {clk_fail_irq_en_i, clk_fail_clr_i, standby_flag_clr_i, bkp_wr_i} = '0;
    {stop_src, rc_req_en_i, want_rc, wakeup_pins_i} = '0;
    {ext_freq_mhz_i, pll_freq_mhz_i, hdiv_sel_i, pdiv_sel_i} = '0;
    {bkp_idx_i, bkp_wdata_i} = '0;
    clk_sel_i = LPMCS_SRC_RC;
    external_reset_pin_n_i = 1'h1;
    clk_en_i = 1'h1;
    resetn_i = 1'h0;
    errors = 0;
    n_compared = 0;
    step(2);
    resetn_i = 1'h1;
    `CHK({sysclk_sel_o, internal_rc_osc_en_o}, {LPMCS_SRC_RC, 1'h1})
    `CHK(calendar_clk_en_o & guard_timer_clk_en_o, 1'h1)
    enter(1'h0, 1'h0, 1'h0);
    `CHK({core_clk_en_o, hclk_en_o, core_domain_clk_on_o}, 3'h3)
    periph_irq_i = 1'h1;
    step();
    periph_irq_i = 1'h0;
    `CHK(core_clk_en_o, 1'h1)
    tick_on = 1'h1;
    ext_osc_on_i = 1'h1;
    ext_freq_mhz_i = 6'h21;
    sel(LPMCS_SRC_EXT);
    `CHK(sysclk_sel_o, LPMCS_SRC_RC)
    ext_freq_mhz_i = 6'h04;
    sel(LPMCS_SRC_EXT);
    `CHK(sysclk_sel_o, LPMCS_SRC_EXT)
    pll_on_i = 1'h1;
    pll_freq_mhz_i = 7'h40;
    sel(LPMCS_SRC_PLL);
    `CHK(sysclk_sel_o, LPMCS_SRC_EXT)
    hdiv_sel_i = 3'h1;
    div_wr_i = 1'h1;
    step();
    div_wr_i = 1'h0;
    cnt = 0;
    repeat (8) begin
      step();
      cnt += int'(hclk_en_o) + int'(pclk_en_o);
    end
    `CHK({hdiv_o, pdiv_o, cnt}, {3'h1, 3'h0, 32'h8})
    enter(1'h1, 1'h0, 1'h1);
    `CHK({core_domain_clk_on_o, pll_en_o, internal_rc_osc_en_o,
      external_crystal_osc_en_o, regulator_lp_o, regulator_on_o}, 6'h03)
    rc_req_en_i = 3'h2;
    want_rc = 3'h2;
    step(2);
    `CHK({regulator_lp_o, rc_grant_o}, 4'h0)
    k = 0;
    while (rc_grant_o !== 3'h2 && k < 80) begin
      step();
      k++;
    end
    bound(80);
    `CHK({rc_grant_o, internal_rc_osc_en_o, regulator_lp_o}, 5'h0A)
    `CHK(k, REG_SETTLE_CYC)
    want_rc = 3'h0;
    step(3);
    for (int i = 0; i < 23; i++) begin
      if (i > 0) enter(1'h1, 1'h0, 1'h0);
      `CHK(core_domain_clk_on_o, 1'h0)
      stop_src = 23'h1 << i;
      step();
      stop_src = '0;
      `CHK({core_domain_clk_on_o, sysclk_sel_o}, {1'h1, LPMCS_SRC_RC})
    end
    enter(1'h1, 1'h0, 1'h0);
    want_rc = 3'h2;
    step(2);
    `CHK({rc_grant_o, internal_rc_osc_en_o, regulator_lp_o}, 5'h0A)
    {want_rc, stop_src} = {3'h0, 23'h1};
    step();
    stop_src = '0;
    sel(LPMCS_SRC_EXT);
    `CHK(sysclk_sel_o, LPMCS_SRC_EXT)
    tick_on = 1'h0;
    k = 0;
    while (sysclk_sel_o !== LPMCS_SRC_RC && k < 40) begin
      step();
      k++;
    end
    bound(40);
    `CHK({k > 18, clk_fail_flag_o, clk_fail_irq_o}, 3'h6)
    clk_fail_irq_en_i = 1'h1;
    step();
    `CHK(clk_fail_irq_o, 1'h1)
    bkp_wr_i = 1'h1;
    for (int i = 0; i < 5; i++) begin
      bkp_idx_i = BKP_IDX_W'(i);
      bkp_wdata_i = 32'hA5A50000 + BKP_W'(i);
      step();
    end
    bkp_wr_i = 1'h0;
    for (int j = 0; j < 4; j++) begin
      enter(1'h1, 1'h1, 1'h0);
      step();
      `CHK({regulator_on_o, core_domain_rst_n_o, pll_en_o, internal_rc_osc_en_o,
        external_crystal_osc_en_o, standby_flag_o, calendar_clk_en_o},
        7'h03)
      case (j)
        0: external_reset_pin_n_i = 1'h0;
        1: independent_guard_timer_rst_i = 1'h1;
        2: wakeup_pins_i = 2'h1;
        default: cal_sb = 1'h1;
      endcase
      step();
      {independent_guard_timer_rst_i, cal_sb} = '0;
      external_reset_pin_n_i = 1'h1;
      `CHK(core_domain_rst_n_o, 1'h1)
    end
    `CHK({hdiv_o, clk_fail_flag_o}, 4'h0)
    standby_flag_clr_i = 1'h1;
    step();
    standby_flag_clr_i = 1'h0;
    `CHK(standby_flag_o, 1'h0)
    resetn_i = 1'h0;
    step(2);
    resetn_i = 1'h1;
    `CHK({sysclk_sel_o, bkp_rdata_o}, {LPMCS_SRC_RC, 32'h0})
    for (int i = 0; i < 6; i++) begin
      bkp_idx_i = BKP_IDX_W'(i);
      step();
      `CHK(bkp_rdata_o, (i < 5) ? 32'hA5A50000 + BKP_W'(i) : 32'h0)
    end
    complete_run();
  end
endmodule // tb_lpmcs_top
